// [design/lcc_pkg.sv]
// Operation
// - Cluster generates ten shared control signals.
// - Clock and clock enable work as pairs.
// - Deasserted enable stops the group clock.
// - Each cluster clock has its own edge.
// - Preset loads a one through asynchronous load.
// - Controls come from column or local lines.
// - Each cell has a full four-input table.
// - Register acts as D, T, JK or SR.
// - Asynchronous load data is the fourth input.
// - Combinational result can bypass the register.
// - Three outputs each pick table or register.
// - Register may feed its own table.
// - Table and register cascade to next cell.
// - Subtract inverts B and forces carry one.
// - First cell receives forced carry on subtract.
// - Each cell sees eight possible inputs.
// - Register controls exist in every mode.
// - Cell runs in normal or arithmetic mode.
// - Clear wins over simultaneous asynchronous load.
// - Synchronous clear and load are cluster wide.
// - Cluster carry selects between precomputed chains.
// - Enabled chip clear resets every register.
package lcc_pkg;

  // ==========================================================================
  // Sizes of the cluster.
  localparam int NUM_CELLS = 10;           // Cells in the cluster.
  localparam int NUM_CTL   = 10;           // Shared control signals.
  localparam int NUM_COL   = 4;            // Column clock lines.
  localparam int NUM_LOC   = 4;            // Local routing control lines.
  localparam int SEL_W     = 3;            // Source select width per control.
  localparam int CSEL_W    = 30;           // All control selects together.
  localparam int CELL_W    = 28;           // Cell configuration word width.
  localparam int CTRL_W    = 4;            // Control register width.
  localparam int DATA_W    = 40;           // Four data inputs per cell.

  // ==========================================================================
  // Register byte addresses.
  localparam logic [11:0] ADDR_CTRL = 12'h000;  // Control register.
  localparam logic [11:0] ADDR_CSEL = 12'h004;  // Control source selects.
  localparam logic [11:0] ADDR_STAT = 12'h008;  // Register state, read only.
  localparam logic [5:0]  CELL_PAGE = 6'h01;    // Cell words start at 0x40.
  localparam logic [3:0]  CELL_CNT  = 4'ha;     // Number of cell words.

  // ==========================================================================
  // Control register fields and reset values.
  localparam int CTRL_DEVCLR_EN = 0;       // Chip-wide clear pin enable.
  localparam int CTRL_INIT      = 1;       // Write one to load power-up values.
  localparam int CTRL_FALL0     = 2;       // Clock zero uses its falling edge.
  localparam int CTRL_FALL1     = 3;       // Clock one uses its falling edge.
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 4'hd;  // Stored control bits.
  localparam logic [CTRL_W-1:0] CTRL_RST   = 4'h0;
  localparam logic [CSEL_W-1:0] CSEL_RST   = 30'h00000000;
  localparam logic [CELL_W-1:0] CELL_RST   = 28'h0000000;

  // ==========================================================================
  // Control signal indices, also the slot order in the select register.
  localparam int CTL_CLK0    = 0;
  localparam int CTL_CLK1    = 1;
  localparam int CTL_ENA0    = 2;
  localparam int CTL_ENA1    = 3;
  localparam int CTL_ACLR0   = 4;
  localparam int CTL_ACLR1   = 5;
  localparam int CTL_SCLR    = 6;
  localparam int CTL_ALOAD   = 7;
  localparam int CTL_SLOAD   = 8;
  localparam int CTL_ADDNSUB = 9;

  // ==========================================================================
  // Cell configuration word fields.
  localparam int LUT_LSB    = 0;           // Sixteen-bit truth table.
  localparam int FF_LSB     = 16;          // Register kind, two bits.
  localparam int GRP_BIT    = 18;          // Clock group select.
  localparam int ACLR_BIT   = 19;          // Asynchronous clear select.
  localparam int MODE_BIT   = 20;          // Normal or arithmetic.
  localparam int OUTA_BIT   = 21;          // Row output A takes register.
  localparam int OUTB_BIT   = 22;          // Row output B takes register.
  localparam int OUTL_BIT   = 23;          // Local output takes register.
  localparam int PACK_BIT   = 24;          // Register feeds table input 3.
  localparam int LCHAIN_BIT = 25;          // Table input 0 from table cascade.
  localparam int RCHAIN_BIT = 26;          // Register data from register cascade.
  localparam int INIT_BIT   = 27;          // Power-up value of the register.

  // Register kinds.
  typedef enum logic [1:0] {LCC_FF_D, LCC_FF_T, LCC_FF_JK, LCC_FF_SR} lcc_ff_t;

  // Cell modes.
  typedef enum logic {LCC_MODE_NORMAL, LCC_MODE_ARITH} lcc_mode_t;

endpackage

// [design/lcc_logic_cluster.sv]
`timescale 1ns/10ps
module lcc_logic_cluster (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output wire logic [31:0]                 prdata,
  output wire logic                        pready,
  output wire logic                        pslverr,
  input  wire logic [lcc_pkg::NUM_COL-1:0] col_clk,
  input  wire logic [lcc_pkg::NUM_LOC-1:0] local_ctrl,
  input  wire logic                        chip_wide_clear_n,
  input  wire logic [lcc_pkg::DATA_W-1:0]  data_in,
  input  wire logic                        cluster_carry_in,
  input  wire logic                        reg_chain_in,
  output wire logic [lcc_pkg::NUM_CELLS-1:0] row_out_a,
  output wire logic [lcc_pkg::NUM_CELLS-1:0] row_out_b,
  output wire logic [lcc_pkg::NUM_CELLS-1:0] local_out,
  output wire logic                        lut_chain_out,
  output wire logic                        reg_chain_out,
  output wire logic                        cluster_carry_out
);
  import lcc_pkg::*;

  // ==========================================================================
  // Declarations.
  logic [CTRL_W-1:0]    ctrl_r;                  // Control register.
  logic [CSEL_W-1:0]    csel_r;                  // Control source selects.
  logic [CELL_W-1:0]    cell_cfg_r [NUM_CELLS];  // Cell configuration words.
  logic                 init_r;                  // One-cycle power-up load.
  logic                 pready_r;                // Bus ready.
  logic                 pslverr_r;               // Bus error.
  logic [31:0]          prdata_r;                // Bus read data.
  logic                 setup_w;                 // Bus setup phase.
  logic                 wr_w;                    // Write completes this edge.
  logic                 cell_hit_w;              // Address names a cell word.
  logic                 hit_w;                   // Address is mapped.
  logic [31:0]          rd_w;                    // Read data selection.
  logic [7:0]           ctl_src_w;               // Candidate control sources.
  logic [NUM_CTL-1:0]   ctl_w;                   // Shared control signals.
  logic [1:0]           clk_prev_r;              // Last level of each clock.
  logic [1:0]           clk_tick_w;              // Active edge of each clock.
  logic                 cluster_clock_one;       // Second cluster clock level.
  logic                 cluster_clock_enable_one; // Second cluster enable.
  logic                 chip_clr_w;              // Chip clear in force.
  logic                 cin_eff_w;               // Carry that picks the chain.
  logic [NUM_CELLS-1:0] f_w;                     // Combinational cell results.
  logic [NUM_CELLS-1:0] q_w;                     // Cell register states.
  logic [NUM_CELLS-1:0] cy0_w;                   // Carry out, chain zero.
  logic [NUM_CELLS-1:0] cy1_w;                   // Carry out, chain one.
  logic [NUM_CELLS-1:0] tick_w;                  // Enabled clock edge per cell.
  logic [NUM_CELLS-1:0] async_w;                 // Any asynchronous action.
  logic [NUM_CELLS-1:0] carry_chain_zero_in;     // Chain zero into each cell.
  logic [NUM_CELLS-1:0] carry_chain_one_in;      // Chain one into each cell.
  logic [NUM_CELLS-1:0] lutc_in_w;               // Table cascade into each cell.
  logic [NUM_CELLS-1:0] rc_in_w;                 // Register cascade into each cell.
  logic [NUM_CELLS-1:0] row_a_r;                 // Row output A.
  logic [NUM_CELLS-1:0] row_b_r;                 // Row output B.
  logic [NUM_CELLS-1:0] local_r;                 // Local output.
  logic                 lut_chain_r;             // Last table result.
  logic                 carry_out_r;             // Cluster carry out.

  // ==========================================================================
  // APB slave.
  // The answer is prepared in the setup cycle, so every access has no wait.
  assign setup_w = psel & ~penable;
  assign wr_w    = psel & penable & pready_r & pwrite;
  assign cell_hit_w = (paddr[1:0] == 2'b00) && (paddr[11:6] == CELL_PAGE) &&
                      (paddr[5:2] < CELL_CNT);
  assign hit_w = (paddr == ADDR_CTRL) || (paddr == ADDR_CSEL) ||
                 (paddr == ADDR_STAT) || cell_hit_w;

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_w = 32'h00000000;
    if (paddr == ADDR_CTRL) begin
      rd_w = 32'(ctrl_r);
    end else if (paddr == ADDR_CSEL) begin
      rd_w = 32'(csel_r);
    end else if (paddr == ADDR_STAT) begin
      rd_w = 32'({carry_out_r, q_w});
    end else if (cell_hit_w) begin
      rd_w = 32'(cell_cfg_r[paddr[5:2]]);
    end
  end

  // Handshake and read data, loaded during the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~hit_w;
      if (setup_w && !pwrite) begin
        prdata_r <= rd_w;
      end
    end
  end

  // Control and select registers; the power-up load bit is a pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      csel_r <= CSEL_RST;
      init_r <= 1'b0;
    end else begin
      init_r <= wr_w && (paddr == ADDR_CTRL) && pwdata[CTRL_INIT];
      if (wr_w && (paddr == ADDR_CTRL)) begin
        ctrl_r <= pwdata[CTRL_W-1:0] & CTRL_WMASK;
      end
      if (wr_w && (paddr == ADDR_CSEL)) begin
        csel_r <= pwdata[CSEL_W-1:0];
      end
    end
  end

  // Cell configuration words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NUM_CELLS; k++) begin
        cell_cfg_r[k] <= CELL_RST;
      end
    end else if (wr_w && cell_hit_w) begin
      cell_cfg_r[paddr[5:2]] <= pwdata[CELL_W-1:0];
    end
  end

  // ==========================================================================
  // Shared control generation.
  // Each of the ten controls picks a column clock line or a local line.
  assign ctl_src_w = {local_ctrl, col_clk};
  always_comb begin
    ctl_w = '0;
    for (int k = 0; k < NUM_CTL; k++) begin
      ctl_w[k] = ctl_src_w[csel_r[k*SEL_W +: SEL_W]];
    end
  end
  assign cluster_clock_one        = ctl_w[CTL_CLK1];
  assign cluster_clock_enable_one = ctl_w[CTL_ENA1];

  // Last clock levels, for edge detection on the system clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_r <= 2'b00;
    end else begin
      clk_prev_r <= {cluster_clock_one, ctl_w[CTL_CLK0]};
    end
  end

  // Each clock has its own polarity, so one source can serve both edges.
  always_comb begin
    clk_tick_w[0] = ctrl_r[CTRL_FALL0] ? (clk_prev_r[0] & ~ctl_w[CTL_CLK0]) :
                                         (~clk_prev_r[0] & ctl_w[CTL_CLK0]);
    clk_tick_w[1] = ctrl_r[CTRL_FALL1] ? (clk_prev_r[1] & ~cluster_clock_one) :
                                         (~clk_prev_r[1] & cluster_clock_one);
  end

  // The chip clear pin only acts once software has enabled it.
  assign chip_clr_w = ctrl_r[CTRL_DEVCLR_EN] & ~chip_wide_clear_n;

  // Subtraction forces the carry that enters the first cell to one.
  assign cin_eff_w = ctl_w[CTL_ADDNSUB] | cluster_carry_in;

  // Chains into each cell; the first cell starts both carry chains.
  assign carry_chain_zero_in = {cy0_w[NUM_CELLS-2:0], 1'b0};
  assign carry_chain_one_in  = {cy1_w[NUM_CELLS-2:0], 1'b1};
  assign lutc_in_w = {f_w[NUM_CELLS-2:0], 1'b0};
  assign rc_in_w   = {q_w[NUM_CELLS-2:0], reg_chain_in};

  // ==========================================================================
  // Cells.
  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    logic [3:0]        d_w;       // Local data inputs.
    logic [CELL_W-1:0] cfg_w;     // This cell's configuration.
    logic [3:0]        idx_w;     // Table address.
    logic              lut_w;     // Table result.
    logic              a_w;       // Operand A.
    logic              b_w;       // Operand B after optional inversion.
    logic              s0_w;      // Sum for chain zero.
    logic              s1_w;      // Sum for chain one.
    logic              sum_w;     // Selected sum.
    logic              x_w;       // Register data after cascade choice.
    logic              nxt_w;     // Register next state by kind.
    logic              aclr_w;    // Selected asynchronous clear.
    logic              q_cell_r;  // The cell register.
    lcc_mode_t         mode_w;    // Cell mode.
    lcc_ff_t           ff_w;      // Register kind.

    assign d_w    = data_in[4*i +: 4];
    assign cfg_w  = cell_cfg_r[i];
    assign mode_w = lcc_mode_t'(cfg_w[MODE_BIT]);
    assign ff_w   = lcc_ff_t'(cfg_w[FF_LSB +: 2]);

    // Table inputs with cascade and register packing options.
    always_comb begin
      idx_w[0] = cfg_w[LCHAIN_BIT] ? lutc_in_w[i] : d_w[0];
      idx_w[1] = d_w[1];
      idx_w[2] = d_w[2];
      idx_w[3] = cfg_w[PACK_BIT] ? q_cell_r : d_w[3];
      lut_w    = cfg_w[LUT_LSB + 32'(idx_w)];
    end

    // Carry-select arithmetic: both sums are formed, the carry picks one.
    always_comb begin
      a_w   = d_w[1];
      b_w   = d_w[2] ^ ctl_w[CTL_ADDNSUB];
      s0_w  = a_w ^ b_w ^ carry_chain_zero_in[i];
      s1_w  = a_w ^ b_w ^ carry_chain_one_in[i];
      sum_w = cin_eff_w ? s1_w : s0_w;
    end
    assign cy0_w[i] = (a_w & b_w) | (carry_chain_zero_in[i] & (a_w ^ b_w));
    assign cy1_w[i] = (a_w & b_w) | (carry_chain_one_in[i] & (a_w ^ b_w));
    assign f_w[i]   = (mode_w == LCC_MODE_ARITH) ? sum_w : lut_w;

    // Register kind; the second control of JK and SR is the fourth input.
    always_comb begin
      x_w = cfg_w[RCHAIN_BIT] ? rc_in_w[i] : f_w[i];
      unique case (ff_w)
        LCC_FF_D:  nxt_w = x_w;
        LCC_FF_T:  nxt_w = q_cell_r ^ x_w;
        LCC_FF_JK: nxt_w = (x_w & ~q_cell_r) | (~d_w[3] & q_cell_r);
        LCC_FF_SR: nxt_w = x_w | (~d_w[3] & q_cell_r);
      endcase
    end

    // Enabled edge of this cell's clock group, paired with its enable.
    assign tick_w[i] = cfg_w[GRP_BIT] ?
                       (clk_tick_w[1] & cluster_clock_enable_one) :
                       (clk_tick_w[0] & ctl_w[CTL_ENA0]);
    assign aclr_w     = cfg_w[ACLR_BIT] ? ctl_w[CTL_ACLR1] : ctl_w[CTL_ACLR0];
    assign async_w[i] = chip_clr_w | aclr_w | ctl_w[CTL_ALOAD];

    // Register update: chip clear, clear, load, power-up load, then edge.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        q_cell_r <= 1'b0;
      end else if (chip_clr_w) begin
        q_cell_r <= 1'b0;
      end else if (aclr_w) begin
        q_cell_r <= 1'b0;
      end else if (ctl_w[CTL_ALOAD]) begin
        q_cell_r <= d_w[3];
      end else if (init_r) begin
        q_cell_r <= cfg_w[INIT_BIT];
      end else if (tick_w[i]) begin
        if (ctl_w[CTL_SCLR]) begin
          q_cell_r <= 1'b0;
        end else if (ctl_w[CTL_SLOAD]) begin
          q_cell_r <= d_w[3];
        end else begin
          q_cell_r <= nxt_w;
        end
      end
    end
    assign q_w[i] = q_cell_r;
  end

  // ==========================================================================
  // Output registers; each row and local output picks the table result or the register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_a_r     <= '0;
      row_b_r     <= '0;
      local_r     <= '0;
      lut_chain_r <= 1'b0;
      carry_out_r <= 1'b0;
    end else begin
      for (int k = 0; k < NUM_CELLS; k++) begin
        row_a_r[k] <= cell_cfg_r[k][OUTA_BIT] ? q_w[k] : f_w[k];
        row_b_r[k] <= cell_cfg_r[k][OUTB_BIT] ? q_w[k] : f_w[k];
        local_r[k] <= cell_cfg_r[k][OUTL_BIT] ? q_w[k] : f_w[k];
      end
      lut_chain_r <= f_w[NUM_CELLS-1];
      carry_out_r <= cin_eff_w ? cy1_w[NUM_CELLS-1] : cy0_w[NUM_CELLS-1];
    end
  end

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign row_out_a         = row_a_r;
  assign row_out_b         = row_b_r;
  assign local_out         = local_r;
  assign lut_chain_out     = lut_chain_r;
  assign reg_chain_out     = q_w[NUM_CELLS-1];
  assign cluster_carry_out = carry_out_r;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A setup cycle is always answered in the following access cycle.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready_r && (pslverr_r == !$past(hit_w));
  endsequence
  property p_apb_answer;
    s_setup |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("Setup cycle not answered next cycle.");

  // Clear beats a simultaneous asynchronous load.
  property p_clr_wins;
    (ctl_w[CTL_ACLR0] && ctl_w[CTL_ALOAD] && !cell_cfg_r[0][ACLR_BIT]) |=> !q_w[0];
  endproperty
  a_clr_wins: assert property (p_clr_wins)
    else $error("Asynchronous load beat clear.");

  // An enabled chip clear empties every register.
  property p_chip_clr;
    chip_clr_w |=> (q_w == '0);
  endproperty
  a_chip_clr: assert property (p_chip_clr)
    else $error("Chip clear left a register set.");

  // Without an enabled edge or an override the register holds.
  property p_hold;
    (!tick_w[0] && !async_w[0] && !init_r) |=> $stable(q_w[0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Register changed without an enabled edge.");

  // Synchronous clear on an enabled edge wins over load.
  property p_sclr;
    (tick_w[0] && ctl_w[CTL_SCLR] && ctl_w[CTL_SLOAD] && !async_w[0] && !init_r)
      |=> !q_w[0];
  endproperty
  a_sclr: assert property (p_sclr)
    else $error("Synchronous clear did not win.");

  // Subtract in the first cell gives the two's-complement sum bit.
  property p_sub;
    (ctl_w[CTL_ADDNSUB] && cell_cfg_r[0][MODE_BIT]) |-> (f_w[0] == (data_in[1] ^ data_in[2]));
  endproperty
  a_sub: assert property (p_sub)
    else $error("Subtract sum bit wrong in first cell.");

  // A bypassed output shows the combinational result one cycle later.
  sequence s_bypass;
    !cell_cfg_r[0][OUTA_BIT];
  endsequence
  property p_bypass;
    s_bypass |=> (row_a_r[0] == $past(f_w[0]));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Bypassed output wrong.");

  // A cascaded D register takes its neighbour's value.
  property p_shift;
    (tick_w[1] && cell_cfg_r[1][RCHAIN_BIT] && (cell_cfg_r[1][FF_LSB +: 2] == 2'b00) &&
     !async_w[1] && !init_r && !ctl_w[CTL_SCLR] && !ctl_w[CTL_SLOAD])
      |=> (q_w[1] == $past(q_w[0]));
  endproperty
  a_shift: assert property (p_shift)
    else $error("Register cascade did not shift.");

  // Asynchronous load takes the fourth data input.
  property p_aload;
    (ctl_w[CTL_ALOAD] && !chip_clr_w && !ctl_w[CTL_ACLR0] && !ctl_w[CTL_ACLR1])
      |=> (q_w[0] == $past(data_in[3]));
  endproperty
  a_aload: assert property (p_aload)
    else $error("Asynchronous load took wrong data.");

endmodule

// [dv/lcc_fabric_model.sv]
`timescale 1ns/10ps
// ============================================================================
// Column clock lines as the global network drives them into the cluster.
module lcc_fabric_model #(
  parameter int HALF = 3  // Pclk cycles per half period of the gated line.
) (
  input  wire logic       pclk,
  input  wire logic       run,
  input  wire logic [2:0] lvl,
  output wire logic [3:0] col_clk
);
  logic [3:0] cnt_r;  // Half period counter.
  logic       clk_r;  // Gated column clock, stands low outside a run.

  // Line zero toggles only while a run is requested, so it ends low.
  always_ff @(posedge pclk) begin
    if (!run) begin
      cnt_r <= 4'h0;
      clk_r <= 1'b0;
    end else if (cnt_r == 4'(HALF - 1)) begin
      cnt_r <= 4'h0;
      clk_r <= ~clk_r;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // The upper three lines carry static levels chosen by the bench.
  assign col_clk = {lvl, clk_r};
endmodule

// [dv/testbench.sv]
`timescale 1ns/10ps
// ============================================================================
// Self-checking bench: reads note expectations, a monitor compares them.
module testbench;
  import lcc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, run, chip_wide_clear_n;
  logic        cluster_carry_in, reg_chain_in, pready, pslverr, st, st1, qq, look;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  col_clk, local_ctrl;
  logic [2:0]  lvl;
  logic [39:0] data_in, dv;
  logic [10:0] ex;        // Expected carry out and sum of the adder.
  wire  [32:0] ov;        // Pins: carry out, register chain, table chain, local, row B, row A.
  logic [65:0] o, oq[$];  // Pending pin notes: mask, expected pins.
  logic [63:0] rv;
  logic [64:0] e;
  logic [64:0] q[$];  // Pending notes: error flag, mask, expected data.
  int          err_count, checks_done, seed, n, i, j;

  // The clock runs at 100 MHz.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  lcc_logic_cluster lcc_logic_cluster_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .col_clk, .local_ctrl, .chip_wide_clear_n,
    .data_in, .cluster_carry_in, .reg_chain_in, .row_out_a(ov[9:0]), .row_out_b(ov[19:10]),
    .local_out(ov[29:20]), .lut_chain_out(ov[30]), .reg_chain_out(ov[31]),
    .cluster_carry_out(ov[32]));
  lcc_fabric_model lcc_fabric_model_inst (.pclk, .run, .lvl, .col_clk);

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; a bounded wait guards against a missing pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, m, x,
                     input logic er);
    @(posedge pclk);
    q.push_back({er, m, x});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Lets the partner make one rising and one falling edge on column line zero.
  task automatic tick;
    run <= 1'b1;
    repeat (6) @(posedge pclk);
    run <= 1'b0;
  endtask

  // Notes the pins due once the inputs have passed two registers, then strobes a look.
  task automatic peek(input logic [32:0] m, x);
    repeat (2) @(posedge pclk);
    oq.push_back({m, x});
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask

  // Each look strobe takes the oldest pin note and compares the output pins.
  always @(posedge pclk) begin
    if (look && oq.size() > 0) begin
      o = oq.pop_front();
      checks_done++;
      if ((ov & o[65:33]) !== o[32:0]) begin
        err_count++;
        $display("wrong value at %0t: got %h expected %h", $time, ov & o[65:33], o[32:0]);
      end
    end
  end

  // Each completed transfer takes the oldest note and compares it.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      checks_done++;
      if (((prdata & e[63:32]) !== e[31:0]) || (pslverr !== e[64])) begin
        err_count++;
        $display("wrong value at %0t: got %h %h expected %h %h", $time, pslverr,
                 prdata & e[63:32], e[64], e[31:0]);
      end
    end
  end

  // Main sequence.
  initial begin
    {psel, penable, pwrite, run, cluster_carry_in, reg_chain_in, st, st1, qq, look} = '0;
    {paddr, pwdata, lvl, local_ctrl, data_in} = '0;
    chip_wide_clear_n = 1'b1;
    err_count = 0;
    checks_done = 0;
    seed = 42480;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'hf, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0, 32'hf, {28'h0, CTRL_WMASK}, 1'b0);
    apb(1'b0, 12'hffc, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    // Clocks from columns 0 and 1, enables and sync controls from local lines.
    apb(1'b1, ADDR_CSEL, 32'h3ef9ab08, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_CSEL, 32'h0, 32'h3fffffff, 32'h3ef9ab08, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 12'h040, 32'h0000aaaa, 32'h0, 32'h0, 1'b0);
    // Cell 1 is a D register fed by the register cascade from cell 0.
    apb(1'b1, 12'h044, 32'h04000000, 32'h0, 32'h0, 1'b0);
    for (i = 0; i < 6; i++) begin
      rv = {$random(seed), $random(seed)};
      data_in <= rv[39:0];
      local_ctrl <= {3'h0, rv[40]};
      cluster_carry_in <= rv[41];
      reg_chain_in <= rv[42];
      if (rv[40]) begin
        st1 = st;
        st = rv[0];
      end
      // Odd passes clock the group on the falling edge of its line.
      apb(1'b1, ADDR_CTRL, {29'h0, i[0], 2'h0}, 32'h0, 32'h0, 1'b0);
      tick();
      apb(1'b0, ADDR_STAT, 32'h0, 32'h3ff, {30'h0, st1, st}, 1'b0);
    end
    lvl <= 3'h2;
    local_ctrl <= 4'h8;
    data_in <= 40'h8;
    apb(1'b0, ADDR_STAT, 32'h0, 32'h3ff, 32'h0, 1'b0);
    lvl <= 3'h0;
    apb(1'b0, ADDR_STAT, 32'h0, 32'h3ff, 32'h1, 1'b0);
    local_ctrl <= 4'h0;
    data_in <= 40'h0;
    apb(1'b0, ADDR_STAT, 32'h0, 32'h3ff, 32'h1, 1'b0);
    local_ctrl <= 4'h5;
    data_in <= 40'h9;
    tick();
    apb(1'b0, ADDR_STAT, 32'h0, 32'h3ff, 32'h0, 1'b0);
    local_ctrl <= 4'h8;
    apb(1'b1, ADDR_CTRL, 32'h1, 32'h0, 32'h0, 1'b0);
    local_ctrl <= 4'h0;
    chip_wide_clear_n <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0, 32'h3ff, 32'h0, 1'b0);
    chip_wide_clear_n <= 1'b1;
    apb(1'b1, 12'h040, 32'h0800aaaa, 32'h0, 32'h0, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h2, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_STAT, 32'h0, 32'h3ff, 32'h1, 1'b0);
    // Cell 0 in arithmetic mode, row B shows the register; odd passes subtract.
    apb(1'b1, 12'h040, 32'h00500000, 32'h0, 32'h0, 1'b0);
    qq = 1'b1;
    for (i = 0; i < 4; i++) begin
      rv = {$random(seed), $random(seed)};
      dv = '0;
      for (j = 0; j < 10; j++) begin
        dv[4*j+1] = rv[j];
        dv[4*j+2] = rv[10+j];
      end
      if (i[0]) begin
        ex = {1'b0, rv[9:0]} + {1'b0, ~rv[19:10]} + 11'h1;
        qq = 1'b0;
      end else begin
        ex = {1'b0, rv[9:0]} + {1'b0, rv[19:10]} + {10'h0, rv[21]};
      end
      data_in <= dv;
      local_ctrl <= {i[0], 3'h0};
      cluster_carry_in <= rv[21];
      peek(33'h1c0100401, {ex[10], 11'h0, ex[0], 9'h0, qq, 9'h0, ex[0]});
    end
    complete_run();
  end
endmodule
